// file: logic/eeac_top.sv
// EEPROM access controller: I/O registers, programming sequencer and read path
//
// How it works
// - High address holds only bit eight
// - Low address holds bits seven to zero
// - Data register: write source, read result
// - Mode selects atomic, erase or write
// - Mode writes ignored while programming enabled
// - Reset clears mode unless programming
// - Ready interrupt while idle and enabled
// - Master enable self-clears after four cycles
// - Program enable starts only under master
// - Program enable stays set until done
// - Programming start stalls CPU two cycles
// - Read fetches byte, stalls four cycles
// - No reads or address changes while busy
// - Control bits seven and six read zero
// - Programming survives system reset
// - Write-only needs prior erase
// - Durations timed by calibrated oscillator
`timescale 1ns/1ps
`default_nettype none

`include "eeac_defines.svh"

module eeac_top
    import eeac_pkg::*;
#(
    parameter int NVM_BYTES    = 512,
    parameter int TICK_W       = 16,
    parameter int ATOMIC_TICKS = `EEAC_TICKS(`EEAC_T_ATOMIC_US),
    parameter int SPLIT_TICKS  = `EEAC_TICKS(`EEAC_T_SPLIT_US)
) (
    input  wire logic          ref_clk_in,
    input  wire logic          rst_n_in,
    input  wire logic          por_n_in,
    input  wire logic          cal_osc_clk_in,
    input  wire eeac_io_req_t  io_req_in,
    input  wire logic          glob_irq_enable_in,
    input  wire logic [7:0]    arr_rdata_in,
    output var  logic [7:0]    io_rdata_out,
    output var  logic          cpu_stall_out,
    output var  logic          ready_irq_out,
    output var  eeac_arr_cmd_t arr_cmd_out
);

    // Implemented address bits follow the array size
    function automatic logic [8:0] addr_mask(input int bytes);
        logic [8:0] m;
        m = 9'h0ff;
        if (bytes <= 128) begin
            m = 9'h07f;
        end else if (bytes > 256) begin
            m = 9'h1ff;
        end
        return m;
    endfunction : addr_mask

    function automatic logic [TICK_W-1:0] mode_ticks(input eeac_mode_t m);
        logic [TICK_W-1:0] t;
        t = TICK_W'(SPLIT_TICKS);
        if (m == EEAC_MODE_ATOMIC) begin
            t = TICK_W'(ATOMIC_TICKS);
        end
        return t;
    endfunction : mode_ticks

    // Register hit for one I/O offset
    function automatic logic reg_hit(input eeac_io_req_t r, input logic [5:0] ofs);
        logic hit;
        hit = r.addr == ofs;
        return hit;
    endfunction : reg_hit

    // Erase half of an operation
    function automatic logic mode_erases(input eeac_mode_t m);
        logic e;
        e = 1'b0;
        if (m == EEAC_MODE_ATOMIC || m == EEAC_MODE_ERASE) begin
            e = 1'b1;
        end
        return e;
    endfunction : mode_erases

    // Write half of an operation; alone it cannot raise cleared bits
    function automatic logic mode_writes(input eeac_mode_t m);
        logic w;
        w = 1'b0;
        if (m == EEAC_MODE_ATOMIC || m == EEAC_MODE_WRITE) begin
            w = 1'b1;
        end
        return w;
    endfunction : mode_writes

    // Stall length for the request that starts this cycle
    function automatic logic [2:0] stall_len(input logic prog, input logic rd);
        logic [2:0] n;
        n = 3'h0;
        if (prog) begin
            n = `EEAC_STALL_PROG;
        end else if (rd) begin
            n = `EEAC_STALL_READ;
        end
        return n;
    endfunction : stall_len

    localparam logic [8:0] ADDR_MASK = addr_mask(NVM_BYTES);

    eeac_state_t       state_q;
    eeac_mode_t        mode_q;
    eeac_mode_t        wr_mode;
    logic              rie_q;
    logic [2:0]        mpe_cnt_q;
    logic              mpe_set;
    logic [2:0]        stall_cnt_q;
    logic [2:0]        stall_cnt_d;
    logic [7:0]        data_q;
    logic [8:0]        addr_q;
    logic              busy;
    logic              pe_bit;
    logic              wr_ctrl;
    logic              wr_data;
    logic              wr_addr_lo;
    logic              wr_addr_hi;
    logic              start_prog;
    logic              start_read;
    logic              start_timer;
    logic              rsvd_start;
    logic              timer_done;
    logic [7:0]        ctrl_view;
    logic [7:0]        rdata_d;

    // Register decode; unmapped offsets read zero and ignore writes
    assign wr_ctrl    = io_req_in.wr && reg_hit(io_req_in, `EEAC_OFS_CTRL);
    assign wr_data    = io_req_in.wr && reg_hit(io_req_in, `EEAC_OFS_DATA);
    assign wr_addr_lo = io_req_in.wr && reg_hit(io_req_in, `EEAC_OFS_ADDR_LO);
    assign wr_addr_hi = io_req_in.wr && reg_hit(io_req_in, `EEAC_OFS_ADDR_HI);

    // Mode used for a start comes from the same write
    assign wr_mode    = eeac_mode_t'(io_req_in.wdata[`EEAC_CTRL_MODE_HI:`EEAC_CTRL_MODE_LO]);

    assign busy    = state_q != EEAC_ST_IDLE;
    assign pe_bit  = busy;
    assign mpe_set = mpe_cnt_q != 3'h0;

    // Start only inside the master window and only when idle
    assign start_prog = wr_ctrl && io_req_in.wdata[`EEAC_CTRL_PE] && mpe_set && !busy;
    // A read is refused during programming; software is expected to poll first
    assign start_read = wr_ctrl && io_req_in.wdata[`EEAC_CTRL_RE] && !busy && !start_prog;

    // Reserved mode never reaches the array
    assign rsvd_start  = start_prog && wr_mode == EEAC_MODE_RSVD;
    assign start_timer = start_prog && !rsvd_start;

    // Timer sits on power-on reset, so it keeps counting through a system reset
    eeac_prog_timer #(
        .CNT_W      (TICK_W)
    ) u_timer (
        .ref_clk_in (ref_clk_in),
        .por_n_in   (por_n_in),
        .osc_clk_in (cal_osc_clk_in),
        .start_in   (start_timer),
        .ticks_in   (mode_ticks(wr_mode)),
        .done_out   (timer_done)
    );

    // Sequencer on power-on reset only, so a system reset cannot cut a cycle short
    always_ff @(posedge ref_clk_in or negedge por_n_in) begin
        if (!por_n_in) begin
            state_q <= EEAC_ST_IDLE;
        end else begin
            case (state_q)
                EEAC_ST_IDLE: begin
                    if (start_prog) begin
                        if (rsvd_start) begin
                            state_q <= EEAC_ST_SKIP;
                        end else begin
                            state_q <= EEAC_ST_PROG;
                        end
                    end
                end
                EEAC_ST_PROG: begin
                    if (timer_done) begin
                        state_q <= EEAC_ST_IDLE;
                    end
                end
                EEAC_ST_SKIP: begin
                    state_q <= EEAC_ST_IDLE;
                end
                default: begin
                    state_q <= EEAC_ST_IDLE;
                end
            endcase
        end
    end

    // Mode field is kept through a system reset while busy
    always_ff @(posedge ref_clk_in or negedge por_n_in) begin
        if (!por_n_in) begin
            mode_q <= eeac_mode_t'(`EEAC_RST_MODE);
        end else if (!rst_n_in) begin
            if (!busy) begin
                mode_q <= eeac_mode_t'(`EEAC_RST_MODE);
            end
        end else if (wr_ctrl && !pe_bit) begin
            mode_q <= wr_mode;
        end
    end

    // Array command: latched address and data for the whole cycle
    always_ff @(posedge ref_clk_in or negedge por_n_in) begin
        if (!por_n_in) begin
            arr_cmd_out <= '0;
        end else begin
            arr_cmd_out.read <= rst_n_in && start_read;
            if (start_prog) begin
                arr_cmd_out.addr  <= addr_q;
                arr_cmd_out.wdata <= data_q;
                // Write-only never erases; an unerased target ends up as the AND of its old byte and the new data
                arr_cmd_out.erase <= mode_erases(wr_mode);
                arr_cmd_out.write <= mode_writes(wr_mode);
            end else if (timer_done || state_q != EEAC_ST_PROG) begin
                arr_cmd_out.erase <= 1'b0;
                arr_cmd_out.write <= 1'b0;
                if (!busy) begin
                    arr_cmd_out.addr <= addr_q;
                end
            end
        end
    end

    // Master program enable window
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mpe_cnt_q <= 3'h0;
        end else if (wr_ctrl && io_req_in.wdata[`EEAC_CTRL_MPE] && !mpe_set) begin
            mpe_cnt_q <= `EEAC_MPE_WINDOW;
        end else if (mpe_set) begin
            mpe_cnt_q <= mpe_cnt_q - 3'h1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rie_q <= 1'b0;
        end else if (wr_ctrl) begin
            rie_q <= io_req_in.wdata[`EEAC_CTRL_RIE];
        end
    end

    // CPU stall after a programming start or a read; a new start reloads it
    always_comb begin
        stall_cnt_d = stall_cnt_q;
        if (start_prog || start_read) begin
            stall_cnt_d = stall_len(start_prog, start_read);
        end else if (stall_cnt_q != 3'h0) begin
            stall_cnt_d = stall_cnt_q - 3'h1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stall_cnt_q   <= 3'h0;
            cpu_stall_out <= 1'b0;
        end else begin
            stall_cnt_q   <= stall_cnt_d;
            cpu_stall_out <= stall_cnt_d != 3'h0;
        end
    end

    // Data register; the fetched byte lands one cycle after the strobe
    // A capture and a software write in one cycle: the capture wins
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            data_q <= `EEAC_RST_DATA;
        end else if (arr_cmd_out.read) begin
            data_q <= arr_rdata_in;
        end else if (wr_data) begin
            data_q <= io_req_in.wdata;
        end
    end

    // Address is frozen while busy; unimplemented bits never store
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            addr_q <= `EEAC_RST_ADDR;
        end else if (!busy) begin
            if (wr_addr_lo) begin
                addr_q[7:0] <= io_req_in.wdata & ADDR_MASK[7:0];
            end
            if (wr_addr_hi) begin
                addr_q[8] <= io_req_in.wdata[0] & ADDR_MASK[8];
            end
        end
    end

    // Ready interrupt is a level, not a pulse
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ready_irq_out <= 1'b0;
        end else begin
            ready_irq_out <= rie_q && glob_irq_enable_in && !busy;
        end
    end

    // Read strobe bit always reads back as zero
    always_comb begin
        ctrl_view                     = 8'h00;
        ctrl_view[`EEAC_CTRL_MODE_HI] = mode_q[1];
        ctrl_view[`EEAC_CTRL_MODE_LO] = mode_q[0];
        ctrl_view[`EEAC_CTRL_RIE]     = rie_q;
        ctrl_view[`EEAC_CTRL_MPE]     = mpe_set;
        ctrl_view[`EEAC_CTRL_PE]      = pe_bit;
        ctrl_view[`EEAC_CTRL_RE]      = 1'b0;
    end

    always_comb begin
        rdata_d = 8'h00;
        case (io_req_in.addr)
            `EEAC_OFS_CTRL: begin
                rdata_d = ctrl_view;
            end
            `EEAC_OFS_DATA: begin
                rdata_d = data_q;
            end
            `EEAC_OFS_ADDR_LO: begin
                rdata_d = addr_q[7:0];
            end
            `EEAC_OFS_ADDR_HI: begin
                rdata_d = {7'h00, addr_q[8]};
            end
            default: begin
                rdata_d = 8'h00;
            end
        endcase
    end

    // Registered read data holds until the next read
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            io_rdata_out <= 8'h00;
        end else if (io_req_in.rd) begin
            io_rdata_out <= rdata_d;
        end
    end

endmodule : eeac_top

`default_nettype wire

// file: logic/eeac_defines.svh
// Offsets, field positions, reset values and timing figures of the EEPROM access controller
`ifndef EEAC_DEFINES_SVH
`define EEAC_DEFINES_SVH

// I/O register offsets
`define EEAC_OFS_CTRL      6'h1c
`define EEAC_OFS_DATA      6'h1d
`define EEAC_OFS_ADDR_LO   6'h1e
`define EEAC_OFS_ADDR_HI   6'h1f

// Control register field positions
`define EEAC_CTRL_MODE_HI  5
`define EEAC_CTRL_MODE_LO  4
`define EEAC_CTRL_RIE      3
`define EEAC_CTRL_MPE      2
`define EEAC_CTRL_PE       1
`define EEAC_CTRL_RE       0

// Reset values
`define EEAC_RST_DATA      8'h00
`define EEAC_RST_MODE      2'h0
`define EEAC_RST_ADDR      9'h000

// Stall and window lengths in system clock cycles
`define EEAC_STALL_PROG    3'h2
`define EEAC_STALL_READ    3'h4
`define EEAC_MPE_WINDOW    3'h4

// Programming times in microseconds, timed by the calibrated oscillator
`define EEAC_T_ATOMIC_US   3400
`define EEAC_T_SPLIT_US    1800
`define EEAC_OSC_KHZ       8000
`define EEAC_TICKS(us)     ((us) * `EEAC_OSC_KHZ / 1000)

`endif

// file: logic/eeac_pkg.sv
// Types shared by the EEPROM access controller files
package eeac_pkg;

    typedef enum logic [1:0] {
        EEAC_MODE_ATOMIC = 2'h0,
        EEAC_MODE_ERASE  = 2'h1,
        EEAC_MODE_WRITE  = 2'h2,
        EEAC_MODE_RSVD   = 2'h3
    } eeac_mode_t;

    typedef enum logic [2:0] {
        EEAC_ST_IDLE = 3'h1,
        EEAC_ST_PROG = 3'h2,
        EEAC_ST_SKIP = 3'h4
    } eeac_state_t;

    typedef struct packed {
        logic [5:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } eeac_io_req_t;

    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] wdata;
        logic       erase;
        logic       write;
        logic       read;
    } eeac_arr_cmd_t;

endpackage : eeac_pkg

// file: logic/eeac_prog_timer.sv
// Programming duration timer counting calibrated oscillator periods
`timescale 1ns/1ps
`default_nettype none

module eeac_prog_timer
    import eeac_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic             ref_clk_in,
    input  wire logic             por_n_in,
    input  wire logic             osc_clk_in,
    input  wire logic             start_in,
    input  wire logic [CNT_W-1:0] ticks_in,
    output var  logic             done_out
);

    logic             osc_s1_q;
    logic             osc_s2_q;
    logic             osc_s3_q;
    logic             osc_edge;
    logic [CNT_W-1:0] cnt_q;

    always_ff @(posedge ref_clk_in or negedge por_n_in) begin
        if (!por_n_in) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
        end else begin
            osc_s1_q <= osc_clk_in;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end

    // Rising oscillator edge, seen once stages two and three settle
    assign osc_edge = osc_s2_q && !osc_s3_q;

    always_ff @(posedge ref_clk_in or negedge por_n_in) begin
        if (!por_n_in) begin
            cnt_q    <= '0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (start_in) begin
                cnt_q <= ticks_in;
            end else if (osc_edge && cnt_q != '0) begin
                cnt_q <= cnt_q - 1'b1;
                if (cnt_q == CNT_W'(1)) begin
                    done_out <= 1'b1;
                end
            end
        end
    end

endmodule : eeac_prog_timer

`default_nettype wire

// file: sim/eeac_array_model.sv
// Behavioural byte array standing behind the access controller
`timescale 1ns/1ps
`default_nettype none

module eeac_array_model
    import eeac_pkg::*;
(
    input  wire logic          ref_clk_in,
    input  wire eeac_arr_cmd_t cmd_in,
    output var  logic [7:0]    rdata_out
);
    logic [7:0] mem_q [512];
    logic [7:0] last_q;
    logic       op_q = 1'b0;

    // Released bus toggles so a late sample never looks valid
    always_comb rdata_out = cmd_in.read ? mem_q[cmd_in.addr] : ~last_q;

    always_ff @(posedge ref_clk_in) begin
        last_q <= rdata_out;
        op_q   <= cmd_in.erase || cmd_in.write;
        if ((cmd_in.erase || cmd_in.write) && !op_q) begin
            // Write alone only clears bits, so an unerased cell is corrupted
            mem_q[cmd_in.addr] <= (cmd_in.erase ? 8'hff : mem_q[cmd_in.addr])
                                & (cmd_in.write ? cmd_in.wdata : 8'hff);
        end
    end
endmodule : eeac_array_model

`default_nettype wire

// file: sim/eeac_top_assertions.sv
// Concurrent checks on the access controller ports
`timescale 1ns/1ps
`default_nettype none

module eeac_top_assertions
    import eeac_pkg::*;
(
    input  wire logic          ref_clk_in,
    input  wire logic          rst_n_in,
    input  wire logic          por_n_in,
    input  wire logic          cal_osc_clk_in,
    input  wire eeac_io_req_t  io_req_in,
    input  wire logic          glob_irq_enable_in,
    input  wire logic [7:0]    arr_rdata_in,
    input  wire logic [7:0]    io_rdata_out,
    input  wire logic          cpu_stall_out,
    input  wire logic          ready_irq_out,
    input  wire eeac_arr_cmd_t arr_cmd_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in || !por_n_in);

    wire logic busy = arr_cmd_out.erase || arr_cmd_out.write;

    sequence s_stall2;
        cpu_stall_out [*2] ##1 !cpu_stall_out;
    endsequence
    sequence s_stall4;
        cpu_stall_out [*4] ##1 !cpu_stall_out;
    endsequence

    a_prog_stall_two: assert property ($rose(busy) |-> s_stall2)
        else $error("program stall not two cycles");
    a_read_stall_four: assert property (arr_cmd_out.read |-> s_stall4)
        else $error("read stall not four cycles");
    a_read_single_pulse: assert property (arr_cmd_out.read |=> !arr_cmd_out.read)
        else $error("array read longer than one cycle");
    a_no_read_busy: assert property (busy |-> !arr_cmd_out.read)
        else $error("array read while programming");
    a_addr_frozen_busy: assert property (busy && $past(busy) |->
        $stable(arr_cmd_out.addr) && $stable(arr_cmd_out.wdata))
        else $error("address or data moved while programming");
    a_prog_min_len: assert property ($rose(busy) |-> busy [*4])
        else $error("programming ended too early");
    a_irq_gated: assert property ((!glob_irq_enable_in || busy) |=> !ready_irq_out)
        else $error("ready interrupt while gated or busy");
    a_rdata_holds: assert property (!$past(io_req_in.rd) |-> $stable(io_rdata_out))
        else $error("read data changed without a read");
endmodule : eeac_top_assertions

`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the access controller
`timescale 1ns/1ps
`default_nettype none
`include "eeac_defines.svh"

module tb;
    import eeac_pkg::*;

    logic          ref_clk_in = 1'b0;
    logic          rst_n_in   = 1'b0;
    logic          por_n_in   = 1'b0;
    logic          osc_clk    = 1'b0;
    logic          irq_en     = 1'b0;
    eeac_io_req_t  req        = '0;
    eeac_arr_cmd_t cmd;
    logic [7:0]    arr_rdata;
    logic [7:0]    rdata;
    logic          stall;
    logic          irq;
    int            fail_count = 0;
    int            n_compared = 0;
    logic [31:0]   seed       = 32'h0000a53b;

    // Short programming times keep the run small
    eeac_top #(.ATOMIC_TICKS(5), .SPLIT_TICKS(3)) uut (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .por_n_in(por_n_in),
        .cal_osc_clk_in(osc_clk), .io_req_in(req), .glob_irq_enable_in(irq_en),
        .arr_rdata_in(arr_rdata), .io_rdata_out(rdata), .cpu_stall_out(stall),
        .ready_irq_out(irq), .arr_cmd_out(cmd));
    eeac_array_model u_arr (.ref_clk_in(ref_clk_in), .cmd_in(cmd), .rdata_out(arr_rdata));

    initial forever #2.5 ref_clk_in = ~ref_clk_in;
    initial forever #25 osc_clk = ~osc_clk;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    function automatic logic [7:0] exp_byte(input logic [1:0] m, input logic [7:0] old, input logic [7:0] d);
        case (m)
            2'h0: return d;
            2'h1: return 8'hff;
            2'h2: return old & d;
            default: return old;
        endcase
    endfunction : exp_byte

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        #1;
        req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge ref_clk_in);
        #1;
        req.wr = 1'b0;
    endtask : wr

    task automatic rdchk(input string n, input logic [5:0] a, input logic [7:0] e);
        @(posedge ref_clk_in);
        #1;
        req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge ref_clk_in);
        #1;
        req.rd = 1'b0;
        if (n != "") chk(n, e, rdata);
    endtask : rdchk

    task automatic wait_idle();
        for (int i = 0; i < 300; i++) begin
            rdchk("", `EEAC_OFS_CTRL, 8'h00);
            if (rdata[`EEAC_CTRL_PE] === 1'b0) return;
        end
        fail_count++;
        $display("BAD idle wait expected 0 seen 1");
        finish_test();
    endtask : wait_idle

    task automatic setup(input logic [8:0] a, input logic [7:0] d);
        wr(`EEAC_OFS_ADDR_HI, {7'h00, a[8]});
        wr(`EEAC_OFS_ADDR_LO, a[7:0]);
        wr(`EEAC_OFS_DATA, d);
    endtask : setup

    task automatic prog(input logic [1:0] m);
        wr(`EEAC_OFS_CTRL, {2'h0, m, 4'h4});
        wr(`EEAC_OFS_CTRL, {2'h0, m, 4'h6});
    endtask : prog

    task automatic nvm_read(input logic [8:0] a, input logic [7:0] e);
        setup(a, 8'h00);
        wr(`EEAC_OFS_CTRL, 8'h01);
        repeat (4) @(posedge ref_clk_in);
        rdchk("nvm data", `EEAC_OFS_DATA, e);
    endtask : nvm_read

    task automatic pulse_rst();
        @(posedge ref_clk_in);
        #1;
        rst_n_in = 1'b0;
        @(posedge ref_clk_in);
        #1;
        rst_n_in = 1'b1;
    endtask : pulse_rst

    initial begin
        logic [31:0] r;
        logic [8:0]  a;
        logic [7:0]  e;
        repeat (3) @(posedge ref_clk_in);
        #1;
        rst_n_in = 1'b1;
        por_n_in = 1'b1;
        rdchk("data reset", `EEAC_OFS_DATA, 8'h00);
        rdchk("unmapped", 6'h10, 8'h00);
        wr(`EEAC_OFS_CTRL, 8'hc8);
        rdchk("ctrl top bits", `EEAC_OFS_CTRL, 8'h08);
        irq_en = 1'b1;
        repeat (2) @(posedge ref_clk_in);
        #1;
        chk("irq on", 8'h01, {7'h00, irq});
        irq_en = 1'b0;
        repeat (2) @(posedge ref_clk_in);
        #1;
        chk("irq off", 8'h00, {7'h00, irq});
        wr(`EEAC_OFS_CTRL, 8'h04);
        rdchk("master set", `EEAC_OFS_CTRL, 8'h04);
        repeat (4) @(posedge ref_clk_in);
        rdchk("master clear", `EEAC_OFS_CTRL, 8'h00);
        wr(`EEAC_OFS_CTRL, 8'h02);
        rdchk("pe no master", `EEAC_OFS_CTRL, 8'h00);
        wr(`EEAC_OFS_ADDR_HI, 8'hff);
        rdchk("addr high", `EEAC_OFS_ADDR_HI, 8'h01);
        e = 8'h00;
        for (int i = 0; i < 4; i++) begin
            r = xs();
            a = (i == 0) ? 9'h1ff : r[8:0];
            for (int m = 0; m < 4; m++) begin
                r = xs();
                setup(a, r[7:0]);
                prog(m[1:0]);
                e = exp_byte(m[1:0], e, r[7:0]);
                wait_idle();
                nvm_read(a, e);
            end
        end
        setup(9'h0a5, 8'h3c);
        prog(2'h1);
        wr(`EEAC_OFS_ADDR_LO, 8'h11);
        wr(`EEAC_OFS_CTRL, 8'h21);
        rdchk("mode busy", `EEAC_OFS_CTRL, 8'h12);
        rdchk("addr busy", `EEAC_OFS_ADDR_LO, 8'ha5);
        pulse_rst();
        rdchk("mode reset busy", `EEAC_OFS_CTRL, 8'h12);
        wait_idle();
        pulse_rst();
        rdchk("mode reset idle", `EEAC_OFS_CTRL, 8'h00);
        nvm_read(9'h0a5, 8'hff);
        finish_test();
    end
endmodule : tb

bind eeac_top eeac_top_assertions u_chk (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .por_n_in(por_n_in),
    .cal_osc_clk_in(cal_osc_clk_in), .io_req_in(io_req_in),
    .glob_irq_enable_in(glob_irq_enable_in), .arr_rdata_in(arr_rdata_in),
    .io_rdata_out(io_rdata_out), .cpu_stall_out(cpu_stall_out),
    .ready_irq_out(ready_irq_out), .arr_cmd_out(arr_cmd_out));

`default_nettype wire
